// ===== rtl/hmp_fire_ctrl.sv
// haptic driver control: power states, mode, fire logic, shorts, bemf timing
// What this block does
// - enable pin high means active; low means shutdown with registers kept.
// - with enable low, bus is acknowledged but no register read or write.
// - standby bit is set after reset; standby keeps registers and bus.
// - setting standby acts at once and stops any playing waveform.
// - software clears standby to leave it; the device becomes ready.
// - soft reset bit acts like power cycle: abort playback, reset registers.
// - soft reset bit clears itself when the reset has finished.
// - playback, calibration, diagnostics start only from internal fire signal.
// - mode field encodes the eight modes; mode 3 uses source select bit.
// - in internal trigger mode writing 0x01 to fire plays the sequencer.
// - fire bit stays set during the sequence and clears when it completes.
// - clearing the fire bit during playback cancels the remaining sequence.
// - in calibration or diagnostics mode fire launches that process instead.
// - in external trigger modes the fire bit reflects the trigger input.
// - realtime, PWM and audio modes assert fire signal, not the fire bit.
// - output short during a process sets overcurrent flag and cuts drive.
// - shorts are checked only in a process; idle shorts found at next start.
// - short present before playing blocks playback until mode is changed.
// - regulator short holds the device in reset, reporting standby; it restarts in default state.
// - drive time field sets drive half period or bemf sampling rate.
// - dissipation interval from 2-bit field precedes high impedance sensing.
// - blanking interval from 2-bit field precedes the bemf conversion.
// - edge trigger: rising edge sets fire, another rising edge clears it.
// - level trigger: fire follows pin, falling edge cancels playback.
`timescale 1ns/1ns
module hmp_fire_ctrl #(
  parameter int WAVE_CYC = hmp_pkg::WAVE_CYC_DFLT,
  parameter int PROC_CYC = hmp_pkg::PROC_CYC_DFLT,
  parameter logic [6:0] BUS_ADDR = hmp_pkg::BUS_ADDR_DFLT
) (
  // system clock, reset, clock enable
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // serial register bus; clock is the link domain
  input  wire logic             link_scl,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  // device pins and analog sense
  input  wire logic             en_pin,
  input  wire logic             trigger_input_pin,
  input  wire logic             out_short,
  input  wire logic             reg_short,
  // status and output stage control
  output hmp_pkg::hmp_pwr_e     power_state,
  output logic                  go_signal,
  output logic                  proc_busy,
  output logic [7:0]            wave_id,
  output logic                  drive_en,
  output logic                  out_hiz,
  output logic                  bemf_conv,
  output logic                  overcurrent_flag
);
  import hmp_pkg::*;

  // link domain: capture each bit on its clock, flag it with a toggle
  logic bit_val_r;
  logic bit_tgl_r;
  always_ff @(posedge link_scl or negedge rst_n) begin
    if (!rst_n) begin
      bit_val_r <= 1'b0;
      bit_tgl_r <= 1'b0;
    end else begin
      bit_val_r <= sda_i;
      bit_tgl_r <= ~bit_tgl_r;
    end
  end

  // two-flop synchronisers: scl, sda, enable, trigger, shorts, toggle
  logic [6:0] in_meta_r;
  logic [6:0] in_sync_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_meta_r <= 7'h03;
      in_sync_r <= 7'h03;
    end else if (ce) begin
      in_meta_r <= {bit_tgl_r, reg_short, out_short, trigger_input_pin,
                    en_pin, sda_i, link_scl};
      in_sync_r <= in_meta_r;
    end
  end
  logic scl_s, sda_s, en_s, trig_s, short_s, regshort_s, tgl_s;
  assign {tgl_s, regshort_s, short_s, trig_s, en_s, sda_s, scl_s} = in_sync_r;

  // previous samples for edge detection
  logic scl_d_r, sda_d_r, trig_d_r, tgl_d_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      trig_d_r <= 1'b0;
      tgl_d_r  <= 1'b0;
    end else if (ce) begin
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
      trig_d_r <= trig_s;
      tgl_d_r  <= tgl_s;
    end
  end

  // a shorted regulator holds all logic except the link flops, synchronisers and edge samples in reset until it is removed
  logic hard_rst, reg_rst, soft_rst_r;
  assign hard_rst = !rst_n || regshort_s;
  assign reg_rst  = hard_rst || soft_rst_r;

  logic bus_start, bus_stop, scl_fall, bit_ev;
  assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign bus_stop  = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_fall  = scl_d_r && !scl_s;
  assign bit_ev    = tgl_s ^ tgl_d_r;

  // register storage
  hmp_modectl_s mode_r;
  hmp_drive_s   drive_r;
  hmp_bemf_s    bemf_r;
  logic         fire_r;
  logic         oc_r;
  logic [7:0]   seq_r [SEQ_DEPTH];
  hmp_proc_e    proc_r;

  // serial bus byte engine state
  hmp_bus_e   bus_ph_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic [7:0] ptr_r;
  logic [7:0] rd_byte_r;
  logic       ack_r;
  logic [7:0] byte_in;
  logic       byte_done;
  logic       wr_stb;
  assign byte_in   = {shift_r, bit_val_r};
  assign byte_done = bit_ev && bit_cnt_r == 4'h7;
  // writes only land while enabled; the address is still acknowledged
  assign wr_stb    = byte_done && bus_ph_r == S_WDATA && en_s;

  // register read view; reads while disabled return released bus
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (!en_s) begin
      v = 8'hff;
    end else if (a >= REG_SEQ_FIRST && a <= REG_SEQ_LAST) begin
      v = seq_r[3'(a - REG_SEQ_FIRST)];
    end else begin
      unique case (a)
        REG_STATUS: begin
          v[STAT_OC_BIT]   = oc_r;
          v[STAT_BUSY_BIT] = proc_r != P_IDLE;
        end
        REG_MODE:  v = {soft_rst_r, mode_r[6:0]};
        REG_FIRE:  v[FIRE_BIT] = fire_r;
        REG_DRIVE: v = drive_r;
        REG_BEMF:  v = bemf_r;
        default:   v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // byte engine: bit counting, address match, pointer, read data
  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      bus_ph_r  <= S_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 7'h00;
      ptr_r     <= 8'h00;
      rd_byte_r <= 8'hff;
      ack_r     <= 1'b0;
    end else if (ce) begin
      if (bus_start) begin
        bus_ph_r  <= S_ADDR;
        bit_cnt_r <= 4'h0;
      end else if (bus_stop) begin
        bus_ph_r <= S_IDLE;
      end else if (bit_ev && bus_ph_r != S_IDLE) begin
        if (bit_cnt_r == 4'h8) begin
          // ninth clock: in a read a master nack ends the transfer
          bit_cnt_r <= 4'h0;
          if (bus_ph_r == S_RDATA && !ack_r) begin
            if (bit_val_r) begin
              bus_ph_r <= S_IDLE;
            end else begin
              ptr_r     <= ptr_r + 8'h01;
              rd_byte_r <= reg_read(ptr_r + 8'h01);
            end
          end
          ack_r <= 1'b0;
        end else begin
          shift_r   <= byte_in[6:0];
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (byte_done) begin
          unique case (bus_ph_r)
            S_ADDR: begin
              ack_r <= byte_in[7:1] == BUS_ADDR;
              if (byte_in[7:1] != BUS_ADDR) begin
                bus_ph_r <= S_IDLE;
              end else if (byte_in[0]) begin
                bus_ph_r  <= S_RDATA;
                rd_byte_r <= reg_read(ptr_r);
              end else begin
                bus_ph_r <= S_REG;
              end
            end
            S_REG: begin
              ptr_r    <= byte_in;
              ack_r    <= 1'b1;
              bus_ph_r <= S_WDATA;
            end
            S_WDATA: begin
              ptr_r <= ptr_r + 8'h01; // sequential write
              ack_r <= 1'b1;
            end
            default: ack_r <= 1'b0;
          endcase
        end
      end
    end
  end

  // data line drive changes on a bus clock fall, and is released at a start or stop
  always_ff @(posedge ref_clk) begin
    if (hard_rst) begin
      sda_oe <= 1'b0;
      sda_o  <= 1'b0;
    end else if (ce) begin
      sda_o <= 1'b0; // open drain: only ever pulls low
      if (bus_start || bus_stop) begin
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        if (bit_cnt_r == 4'h8) begin
          sda_oe <= ack_r;
        end else if (bus_ph_r == S_RDATA) begin
          sda_oe <= ~rd_byte_r[3'h7 - bit_cnt_r[2:0]];
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end

  // decoded write strobes
  logic wr_mode, wr_fire;
  assign wr_mode = wr_stb && ptr_r == REG_MODE;
  assign wr_fire = wr_stb && ptr_r == REG_FIRE;

  // mode control register; soft reset bit self-clears one cycle on
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      mode_r     <= MODE_RESET;
      soft_rst_r <= 1'b0;
    end else if (ce) begin
      soft_rst_r <= wr_mode && byte_in[7];
      if (wr_mode) begin
        mode_r <= {1'b0, byte_in[6:0]};
      end
    end
  end

  // remaining configuration registers
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      drive_r <= DRIVE_RESET;
      bemf_r  <= BEMF_RESET;
    end else if (ce && wr_stb) begin
      if (ptr_r == REG_DRIVE) drive_r <= byte_in;
      if (ptr_r == REG_BEMF)  bemf_r  <= byte_in;
    end
  end

  // waveform sequencer entries
  for (genvar g = 0; g < SEQ_DEPTH; g++) begin : g_seq
    always_ff @(posedge ref_clk) begin
      if (reg_rst) begin
        seq_r[g] <= SEQ_RESET;
      end else if (ce && wr_stb && ptr_r == REG_SEQ_FIRST + 8'(g)) begin
        seq_r[g] <= byte_in;
      end
    end
  end

  // power state and continuous modes
  logic active, cont_mode;
  assign active    = en_s && !mode_r.standby;
  assign cont_mode = mode_r.mode == MODE_REALTIME ||
                     mode_r.mode == MODE_AUDIO_VIBE ||
                     (mode_r.mode == MODE_ANALOG_PWM && drive_r.src_pwm);

  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      power_state <= PWR_STANDBY;
    end else if (ce) begin
      if (!en_s) power_state <= PWR_SHUTDOWN;
      else if (mode_r.standby) power_state <= PWR_STANDBY;
      else power_state <= PWR_READY;
    end
  end

  // internal fire signal: fire bit or a continuous mode, only when active
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      go_signal <= 1'b0;
    end else if (ce) begin
      go_signal <= active && (fire_r || cont_mode);
    end
  end

  // process sequencing
  logic [15:0] proc_cnt_r;
  logic [2:0]  seq_idx_r;
  logic        seq_done_r;
  logic        blocked_r;
  logic        proc_end;   // sequence or process ran to completion
  logic        proc_abort; // short during a running process
  logic        start_short;
  logic        last_step;
  assign last_step = seq_idx_r == 3'(SEQ_DEPTH - 1) ||
                     seq_r[seq_idx_r + 3'h1] == 8'h00;
  assign proc_abort = proc_r != P_IDLE && short_s;
  assign start_short = proc_r == P_IDLE && go_signal && !seq_done_r &&
                       !blocked_r && short_s;
  assign proc_end =
    (proc_r == P_PLAY && proc_cnt_r == 16'(WAVE_CYC - 1) && last_step) ||
    ((proc_r == P_CAL || proc_r == P_DIAG) &&
     proc_cnt_r == 16'(PROC_CYC - 1));

  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      proc_r     <= P_IDLE;
      proc_cnt_r <= 16'h0000;
      seq_idx_r  <= 3'h0;
      wave_id    <= 8'h00;
    end else if (ce) begin
      proc_cnt_r <= proc_cnt_r + 16'h0001;
      if (!go_signal || proc_abort || proc_end) begin
        // standby, shutdown, cleared fire or a short stop at once
        proc_r  <= P_IDLE;
        wave_id <= 8'h00;
      end else if (proc_r == P_IDLE) begin
        proc_cnt_r <= 16'h0000;
        seq_idx_r  <= 3'h0;
        if (!seq_done_r && !blocked_r && !short_s) begin
          if (cont_mode) begin
            proc_r <= P_CONT;
          end else if (mode_r.mode == MODE_CAL) begin
            proc_r <= P_CAL;
          end else if (mode_r.mode == MODE_DIAG) begin
            proc_r <= P_DIAG;
          end else if (seq_r[0] != 8'h00) begin
            proc_r  <= P_PLAY;
            wave_id <= seq_r[0];
          end
        end
      end else if (proc_r == P_PLAY &&
                   proc_cnt_r == 16'(WAVE_CYC - 1)) begin
        proc_cnt_r <= 16'h0000;
        seq_idx_r  <= seq_idx_r + 3'h1;
        wave_id    <= seq_r[seq_idx_r + 3'h1];
      end
    end
  end

  // a finished or refused run waits for the fire signal to drop
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      seq_done_r <= 1'b0;
    end else if (ce) begin
      if (proc_end || start_short ||
          (proc_r == P_IDLE && go_signal && fire_r && !cont_mode &&
           mode_r.mode != MODE_CAL && mode_r.mode != MODE_DIAG &&
           seq_r[0] == 8'h00)) begin
        seq_done_r <= 1'b1;
      end else if (!go_signal) begin
        seq_done_r <= 1'b0;
      end
    end
  end

  // fire bit: software, completion, and the trigger pin
  logic trig_rise, fire_hw_clr;
  assign trig_rise   = trig_s && !trig_d_r;
  assign fire_hw_clr = proc_end || proc_abort || start_short;
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      fire_r <= FIRE_RESET[FIRE_BIT];
    end else if (ce) begin
      unique case (mode_r.mode)
        MODE_LEVEL_TRIG: begin
          fire_r <= trig_s;
        end
        MODE_EDGE_TRIG: begin
          if (trig_rise) fire_r <= ~fire_r;
          else if (wr_fire) fire_r <= byte_in[FIRE_BIT];
          else if (fire_hw_clr) fire_r <= 1'b0;
        end
        default: begin
          // a write landing with completion wins, so a new start is kept
          if (wr_fire) fire_r <= byte_in[FIRE_BIT];
          else if (fire_hw_clr) fire_r <= 1'b0;
        end
      endcase
    end
  end

  // overcurrent flag and the playback block left behind by a prior short
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      oc_r      <= 1'b0;
      blocked_r <= 1'b0;
    end else if (ce) begin
      if (proc_abort || start_short) oc_r <= 1'b1;
      else if (!short_s) oc_r <= 1'b0;
      if (start_short) begin
        blocked_r <= 1'b1;
      end else if (wr_mode && byte_in[2:0] != mode_r.mode) begin
        blocked_r <= 1'b0;
      end
    end
  end

  // bemf cycle: drive, dissipate, high impedance blanking, conversion
  hmp_bemf_e  bph_r;
  logic [11:0] bcnt_r;
  logic [11:0] drv_len, diss_len, blank_len;
  assign drv_len   = 12'(({7'h00, drive_r.drive_time} + 12'h001) *
                         12'(DRV_UNIT_CYC));
  assign diss_len  = 12'(({10'h000, bemf_r.idiss} + 12'h001) *
                         12'(DISS_UNIT_CYC));
  assign blank_len = 12'(({10'h000, bemf_r.blanking} + 12'h001) *
                         12'(BLANK_UNIT_CYC));
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      bph_r  <= B_DRIVE;
      bcnt_r <= 12'h000;
    end else if (ce) begin
      bcnt_r <= bcnt_r + 12'h001;
      if (proc_r == P_IDLE) begin
        bph_r  <= B_DRIVE;
        bcnt_r <= 12'h000;
      end else begin
        unique case (bph_r)
          B_DRIVE: if (bcnt_r == drv_len - 12'h001) begin
            bph_r  <= B_DISS;
            bcnt_r <= 12'h000;
          end
          B_DISS: if (bcnt_r == diss_len - 12'h001) begin
            bph_r  <= B_BLANK;
            bcnt_r <= 12'h000;
          end
          B_BLANK: if (bcnt_r == blank_len - 12'h001) begin
            bph_r  <= B_CONV;
            bcnt_r <= 12'h000;
          end
          B_CONV: begin
            bph_r  <= B_DRIVE;
            bcnt_r <= 12'h000;
          end
        endcase
      end
    end
  end

  // output stage controls; drive is cut the cycle a short is seen
  always_ff @(posedge ref_clk) begin
    if (reg_rst) begin
      drive_en         <= 1'b0;
      out_hiz          <= 1'b0;
      bemf_conv        <= 1'b0;
      proc_busy        <= 1'b0;
      overcurrent_flag <= 1'b0;
    end else if (ce) begin
      // drive stops for dissipation, so the coil current decays first
      drive_en  <= proc_r != P_IDLE && go_signal && !short_s &&
                   bph_r == B_DRIVE;
      out_hiz   <= proc_r != P_IDLE &&
                   (bph_r == B_BLANK || bph_r == B_CONV);
      bemf_conv <= proc_r != P_IDLE && bph_r == B_CONV;
      proc_busy <= proc_r != P_IDLE;
      overcurrent_flag <= oc_r;
    end
  end

endmodule

// ===== rtl/hmp_pkg.sv
// shared constants, register map and types of the haptic mode/fire control
package hmp_pkg;

  // register offsets (byte addresses on the serial bus)
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_MODE      = 8'h01;
  localparam logic [7:0] REG_SEQ_FIRST = 8'h04;
  localparam logic [7:0] REG_SEQ_LAST  = 8'h0b;
  localparam logic [7:0] REG_FIRE      = 8'h0c;
  localparam logic [7:0] REG_DRIVE     = 8'h1e;
  localparam logic [7:0] REG_BEMF      = 8'h1f;

  localparam int SEQ_DEPTH = 8;

  // field positions
  localparam int STAT_OC_BIT   = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int FIRE_BIT      = 0;

  // values after reset
  localparam logic [7:0] MODE_RESET  = 8'h40; // standby set, internal trigger
  localparam logic [7:0] FIRE_RESET  = 8'h00;
  localparam logic [7:0] DRIVE_RESET = 8'h10;
  localparam logic [7:0] BEMF_RESET  = 8'h05;
  localparam logic [7:0] SEQ_RESET   = 8'h00;

  // serial bus address; plain default
  localparam logic [6:0] BUS_ADDR_DFLT = 7'h5a;

  // timing: figures in ns, counts derived from the 250 MHz clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int DRV_UNIT_NS   = 400;
  localparam int DISS_UNIT_NS  = 200;
  localparam int BLANK_UNIT_NS = 200;
  localparam int WAVE_TIME_NS  = 20000;
  localparam int PROC_TIME_NS  = 40000;
  localparam int DRV_UNIT_CYC  = (DRV_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISS_UNIT_CYC = (DISS_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_UNIT_CYC =
    (BLANK_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAVE_CYC_DFLT = (WAVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROC_CYC_DFLT = (PROC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_INT_TRIG   = 3'h0,
    MODE_EDGE_TRIG  = 3'h1,
    MODE_LEVEL_TRIG = 3'h2,
    MODE_ANALOG_PWM = 3'h3,
    MODE_AUDIO_VIBE = 3'h4,
    MODE_REALTIME   = 3'h5,
    MODE_DIAG       = 3'h6,
    MODE_CAL        = 3'h7
  } hmp_mode_e;

  typedef struct packed {
    logic      dev_reset;
    logic      standby;
    logic [2:0] unused;
    hmp_mode_e mode;
  } hmp_modectl_s;

  typedef struct packed {
    logic       src_pwm;
    logic [1:0] unused;
    logic [4:0] drive_time;
  } hmp_drive_s;

  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] blanking;
    logic [1:0] idiss;
  } hmp_bemf_s;

  typedef enum logic [1:0] {PWR_SHUTDOWN, PWR_STANDBY, PWR_READY} hmp_pwr_e;
  typedef enum logic [2:0] {P_IDLE, P_PLAY, P_CAL, P_DIAG, P_CONT} hmp_proc_e;
  typedef enum logic [1:0] {B_DRIVE, B_DISS, B_BLANK, B_CONV} hmp_bemf_e;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_REG, S_WDATA, S_RDATA
  } hmp_bus_e;

endpackage

// ===== bench/hmp_checker.sv
// concurrent checks of the haptic control block, bound to its ports
`timescale 1ns/1ns
module hmp_checker (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // sense inputs
  input wire logic              out_short,
  input wire logic              reg_short,
  // status and output stage
  input wire hmp_pkg::hmp_pwr_e power_state,
  input wire logic              go_signal,
  input wire logic              proc_busy,
  input wire logic              drive_en,
  input wire logic              out_hiz,
  input wire logic              bemf_conv,
  input wire logic              overcurrent_flag
);
  import hmp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // shortest dissipation or blanking phase is 50 cycles, so 8 is safe
  property p_gate; power_state != PWR_READY |-> !go_signal; endproperty
  property p_busy; $rose(proc_busy) |-> $past(go_signal, 2); endproperty
  property p_cut; out_short [*5] |-> !drive_en; endproperty
  property p_oc;
    $changed(overcurrent_flag) |-> overcurrent_flag == $past(out_short, 4);
  endproperty
  property p_diss; $fell(drive_en) && proc_busy |-> !out_hiz [*8]; endproperty
  property p_blank; $rose(out_hiz) |-> !bemf_conv [*8]; endproperty
  property p_conv; bemf_conv |-> $past(out_hiz) ##1 !bemf_conv; endproperty
  property p_rsh;
    reg_short [*5] |-> power_state == PWR_STANDBY && !go_signal && !proc_busy;
  endproperty
  a_gate: assert property (p_gate) else $error("fire while not ready");
  a_busy: assert property (p_busy) else $error("busy without fire");
  a_cut: assert property (p_cut) else $error("drive on into short");
  a_oc: assert property (p_oc) else $error("flag not tied to short");
  a_diss: assert property (p_diss) else $error("hiz too early");
  a_blank: assert property (p_blank) else $error("convert too early");
  a_conv: assert property (p_conv) else $error("bad convert pulse");
  a_rsh: assert property (p_rsh) else $error("alive in reg short");
  c_go: cover property ($rose(go_signal));
  c_conv: cover property (bemf_conv);
  c_oc: cover property ($rose(overcurrent_flag));
endmodule
bind hmp_fire_ctrl hmp_checker chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .out_short(out_short),
  .reg_short(reg_short), .power_state(power_state), .go_signal(go_signal),
  .proc_busy(proc_busy), .drive_en(drive_en), .out_hiz(out_hiz),
  .bemf_conv(bemf_conv), .overcurrent_flag(overcurrent_flag)
);

// ===== bench/hmp_host.sv
// host master model on the two-wire register bus; clock idles high
`timescale 1ns/1ns
module hmp_host (
  // bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  logic r;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // 20 ns low leaves room for the slave's 12 ns turn-around
  task automatic bt(input logic b, output logic s);
    sda_low = !b;
    #20 scl = 1'h1;
    s = sda;
    #10 scl = 1'h0;
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] q, input logic ak);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(!ak, r);
  endtask
  // start waits for the slave to release an ack first
  task automatic st();
    sda_low = 1'h0;
    #20 scl = 1'h1;
    #20 sda_low = 1'h1;
    #20 scl = 1'h0;
  endtask
  task automatic sp();
    sda_low = 1'h1;
    #20 scl = 1'h1;
    #20 sda_low = 1'h0;
    #20;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    st();
    by({hmp_pkg::BUS_ADDR_DFLT, 1'h0}, q, 1'h0);
    by(a, q, 1'h0);
    by(d, q, 1'h0);
    sp();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    st();
    by({hmp_pkg::BUS_ADDR_DFLT, 1'h0}, q, 1'h0);
    by(a, q, 1'h0);
    st();
    by({hmp_pkg::BUS_ADDR_DFLT, 1'h1}, q, 1'h0);
    by(8'hff, d, 1'h0);
    sp();
  endtask
endmodule

// ===== bench/hmp_fire_ctrl_tb.sv
// self-checking bench of the haptic mode, fire and power control block
`timescale 1ns/1ns
module hmp_fire_ctrl_tb;
  import hmp_pkg::*;
  localparam int WCYC = 400; // long waves so one bus read fits inside
  logic       ref_clk = 1'h0;
  logic       rst_n   = 1'h1;
  logic       en_pin  = 1'h1;
  logic       trig    = 1'h0;
  logic       osh     = 1'h0;
  logic       rsh     = 1'h0;
  logic       scl, sda_low, sda_o, sda_oe, go, busy, drv, hiz, conv, oc;
  logic [7:0] wid, q;
  hmp_pwr_e   pst;
  int         n_errors = 0, n_compared = 0, cyc = 0, n;
  wire        sda = !(sda_low || sda_oe); // pulled up
  hmp_fire_ctrl #(.WAVE_CYC(WCYC), .PROC_CYC(WCYC)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'h1), .link_scl(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .en_pin(en_pin),
    .trigger_input_pin(trig), .out_short(osh), .reg_short(rsh),
    .power_state(pst), .go_signal(go), .proc_busy(busy), .wave_id(wid),
    .drive_en(drv), .out_hiz(hiz), .bemf_conv(conv),
    .overcurrent_flag(oc));
  hmp_host host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  always #2 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic ck(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // inputs change 1 ns after a rising edge
  task automatic tk(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    tk(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, q);
    ck(q, exp);
    tk(1);
  endtask
  task automatic wt();
    n = 0;
    while (busy !== 1'h0 && n < 3000) begin
      tk(1);
      n++;
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    #1 rst_n = 1'h0; // a real falling edge clears the link flops
    tk(8);
    rst_n = 1'h1;
    tk(4);
    ck(pst, PWR_STANDBY);
    ck(sda_o, 8'h00);
    rc(REG_MODE, MODE_RESET);
    rc(REG_FIRE, FIRE_RESET);
    rc(REG_DRIVE, DRIVE_RESET);
    rc(REG_BEMF, BEMF_RESET);
    rc(8'h30, 8'h00);
    done("reset");
    // shortest drive time so the sensing loop turns often
    wr(REG_DRIVE, 8'h00);
    wr(REG_MODE, 8'h00);
    tk(4);
    ck(pst, PWR_READY);
    wr(REG_SEQ_FIRST, 8'h11);
    wr(REG_SEQ_FIRST + 8'h01, 8'h22);
    wr(REG_FIRE, 8'h01);
    ck(busy, 8'h01);
    ck(wid, 8'h11);
    rc(REG_FIRE, 8'h01);
    tk(100);
    ck(wid, 8'h22);
    wt();
    ck(n > 200 && n < 500, 8'h01);
    rc(REG_FIRE, 8'h00);
    done("play");
    wr(REG_FIRE, 8'h01);
    wr(REG_FIRE, 8'h00);
    tk(3);
    ck({go, busy}, 8'h00);
    wr(REG_FIRE, 8'h01);
    wr(REG_MODE, 8'h40);
    tk(3);
    ck({go, busy, pst}, {6'h00, PWR_STANDBY});
    wr(REG_FIRE, 8'h00);
    done("cancel");
    for (int m = 4; m < 6; m++) begin
      wr(REG_MODE, 8'(m));
      ck(go, 8'h01);
      rc(REG_FIRE, 8'h00);
    end
    wr(REG_DRIVE, 8'h80);
    wr(REG_MODE, 8'h03);
    ck(go, 8'h01);
    wr(REG_DRIVE, 8'h00);
    ck(go, 8'h00);
    for (int m = 6; m < 8; m++) begin
      wr(REG_MODE, 8'(m));
      wr(REG_FIRE, 8'h01);
      ck(busy, 8'h01);
      ck(wid, 8'h00);
      wt();
      rc(REG_FIRE, 8'h00);
    end
    done("modes");
    wr(REG_MODE, 8'h01);
    trig = 1'h1;
    tk(20);
    trig = 1'h0;
    tk(20);
    ck(go, 8'h01);
    rc(REG_FIRE, 8'h01);
    trig = 1'h1;
    tk(20);
    ck(go, 8'h00);
    trig = 1'h0;
    wr(REG_MODE, 8'h02);
    trig = 1'h1;
    tk(20);
    rc(REG_FIRE, 8'h01);
    trig = 1'h0;
    tk(10);
    ck(go, 8'h00);
    rc(REG_FIRE, 8'h00);
    done("trigger");
    en_pin = 1'h0;
    tk(6);
    ck(pst, PWR_SHUTDOWN);
    wr(REG_SEQ_FIRST, 8'h5a);
    rc(REG_SEQ_FIRST, 8'hff);
    en_pin = 1'h1;
    tk(6);
    rc(REG_SEQ_FIRST, 8'h11);
    done("enable");
    wr(REG_MODE, 8'h00);
    osh = 1'h1;
    tk(20);
    ck(oc, 8'h00);
    wr(REG_FIRE, 8'h01);
    ck({oc, busy}, 8'h02);
    osh = 1'h0;
    wr(REG_FIRE, 8'h00);
    wr(REG_FIRE, 8'h01);
    ck(busy, 8'h00);
    wr(REG_FIRE, 8'h00);
    wr(REG_MODE, 8'h06);
    wr(REG_MODE, 8'h00);
    wr(REG_FIRE, 8'h01);
    ck(busy, 8'h01);
    osh = 1'h1;
    tk(8);
    ck({oc, drv}, 8'h02);
    rc(REG_STATUS, 8'h01);
    osh = 1'h0;
    tk(8);
    ck(oc, 8'h00);
    done("short");
    wr(REG_MODE, 8'h00);
    wr(REG_DRIVE, 8'h07);
    wr(REG_FIRE, 8'h01);
    wr(REG_MODE, 8'h80);
    tk(4);
    ck({busy, pst}, {6'h00, PWR_STANDBY});
    rc(REG_MODE, MODE_RESET);
    rc(REG_DRIVE, DRIVE_RESET);
    wr(REG_MODE, 8'h00);
    rsh = 1'h1;
    tk(8);
    rsh = 1'h0;
    tk(4);
    rc(REG_MODE, MODE_RESET);
    done("resets");
    stop_test();
  end
endmodule
